//--- rtl/dbgpin_pkg.sv
// Package for the debug pin assignment block
// Assumes a single APB slave and one link clock domain
package dbgpin_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] CFG_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_MODE_W = 2;
  localparam int CFG_TRACE_BIT = 2;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  // Pin indices inside a five bit pin vector
  localparam int PIN_TMS = 0;
  localparam int PIN_TCK = 1;
  localparam int PIN_TDI = 2;
  localparam int PIN_TDO = 3;
  localparam int PIN_TRST = 4;
  localparam int NPINS = 5;

  // Pull selection values
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_UP = 2'h1;
  localparam logic [1:0] PULL_DOWN = 2'h2;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    DBGPIN_FULL = 2'h0,
    DBGPIN_NO_TRST = 2'h1,
    DBGPIN_SWD_ONLY = 2'h3,
    DBGPIN_RELEASED = 2'h2
  } dbgpin_mode_t;

  // Per pin control bundle toward the pad ring
  typedef struct packed {
    logic [4:0] debug_owned;
    logic [9:0] pull_sel;
  } dbgpin_pad_ctrl_t;

endpackage : dbgpin_pkg

//--- rtl/dbgpin_top.sv
// Debug pin assignment and release for the combined debug port
// Assumes APB on pclk and the probe clock as link clock on the test clock pin
//
// Contract
// - Any reset returns all five pins to debug
// - Trace output off until explicitly enabled
// - Boundary scan and two wire ports share access
// - Two wire clock and data reuse TCK, TMS
// - Full mode keeps all five pins debug
// - No-reset mode releases only test reset pin
// - Two wire mode keeps only data and clock
// - Disabled mode releases all five pins
// - Pull-ups on reset, data in, mode select
// - Released pins return to general purpose control
// - GPIO reset state mirrors debug configuration
// - Serial data bidirectional, serial clock input only
// - Trace on data out only when enabled
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
module dbgpin_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tck_link,
  input wire logic [4:0] pad_in,
  output logic [4:0] pad_out,
  output logic [4:0] pad_oe,
  output logic [9:0] pad_pull,
  output logic [4:0] debug_owned,
  input wire logic [4:0] gpio_out,
  input wire logic [4:0] gpio_oe,
  output logic [4:0] gpio_in,
  input wire logic port_sdo,
  input wire logic port_sdo_oe,
  input wire logic port_tdo,
  input wire logic port_tdo_oe,
  input wire logic trace_bit,
  output logic [3:0] port_in
);

  // ****************************************
  // Configuration register
  // ****************************************
  dbgpin_pkg::dbgpin_mode_t mode_reg;
  logic trace_en_reg;
  logic [4:0] owned_next;
  logic [4:0] owned_reg;
  logic wr_cfg;

  assign wr_cfg = psel && penable && pwrite && (paddr == dbgpin_pkg::CFG_OFFSET);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= dbgpin_pkg::DBGPIN_FULL;
      trace_en_reg <= 1'b0;
    end else if (wr_cfg) begin
      mode_reg <= dbgpin_pkg::dbgpin_mode_t'(pwdata[dbgpin_pkg::CFG_MODE_LSB +: dbgpin_pkg::CFG_MODE_W]);
      trace_en_reg <= pwdata[dbgpin_pkg::CFG_TRACE_BIT];
    end
  end

  // Pin ownership from mode
  function automatic logic [4:0] owned_of(input dbgpin_pkg::dbgpin_mode_t m);
    case (m)
      dbgpin_pkg::DBGPIN_FULL: owned_of = 5'h1f;
      dbgpin_pkg::DBGPIN_NO_TRST: owned_of = 5'h0f;
      dbgpin_pkg::DBGPIN_SWD_ONLY: owned_of = 5'h03;
      default: owned_of = 5'h00;
    endcase
  endfunction : owned_of

  assign owned_next = owned_of(mode_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      owned_reg <= 5'h1f;
    end else begin
      owned_reg <= owned_next;
    end
  end

  // ****************************************
  // APB slave, zero wait state
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        if (paddr == dbgpin_pkg::CFG_OFFSET) begin
          prdata <= {29'h0, trace_en_reg, mode_reg};
        end else if (paddr == dbgpin_pkg::STATUS_OFFSET) begin
          prdata <= {27'h0, owned_reg};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Link domain: pins sampled on probe clock
  // ****************************************
  logic [1:0] own_tck_s1;
  logic [1:0] own_tck_s2;
  logic [3:0] port_in_reg;

  // Ownership of TRST/TDI crossing to link clock
  always_ff @(posedge tck_link or negedge presetn) begin
    if (!presetn) begin
      own_tck_s1 <= 2'h3;
      own_tck_s2 <= 2'h3;
    end else begin
      own_tck_s1 <= {owned_reg[dbgpin_pkg::PIN_TRST], owned_reg[dbgpin_pkg::PIN_TDI]};
      own_tck_s2 <= own_tck_s1;
    end
  end

  // Both debug ports read the same shared pins
  always_ff @(posedge tck_link or negedge presetn) begin
    if (!presetn) begin
      port_in_reg <= 4'hb;
    end else begin
      port_in_reg[0] <= pad_in[dbgpin_pkg::PIN_TMS];
      port_in_reg[1] <= own_tck_s2[0] ? pad_in[dbgpin_pkg::PIN_TDI] : 1'b1;
      port_in_reg[2] <= 1'b0;
      port_in_reg[3] <= own_tck_s2[1] ? pad_in[dbgpin_pkg::PIN_TRST] : 1'b1;
    end
  end

  // ****************************************
  // Pad multiplexer, registered on pclk
  // ****************************************
  logic [1:0] sdo_s;
  logic [1:0] tdo_s;
  logic [4:0] pad_out_next;
  logic [4:0] pad_oe_next;
  logic [4:0] gin_s1;
  logic [4:0] gin_s2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdo_s <= 2'h0;
      tdo_s <= 2'h0;
      gin_s1 <= 5'h0;
      gin_s2 <= 5'h0;
    end else begin
      sdo_s <= {port_sdo_oe, port_sdo};
      tdo_s <= {port_tdo_oe, port_tdo};
      gin_s1 <= pad_in;
      gin_s2 <= gin_s1;
    end
  end

  always_comb begin
    pad_out_next = gpio_out;
    pad_oe_next = gpio_oe;
    if (owned_reg[dbgpin_pkg::PIN_TMS]) begin
      pad_out_next[dbgpin_pkg::PIN_TMS] = sdo_s[0];
      pad_oe_next[dbgpin_pkg::PIN_TMS] = sdo_s[1];
    end
    if (owned_reg[dbgpin_pkg::PIN_TCK]) begin
      pad_out_next[dbgpin_pkg::PIN_TCK] = 1'b0;
      pad_oe_next[dbgpin_pkg::PIN_TCK] = 1'b0;
    end
    if (owned_reg[dbgpin_pkg::PIN_TDI]) begin
      pad_out_next[dbgpin_pkg::PIN_TDI] = 1'b0;
      pad_oe_next[dbgpin_pkg::PIN_TDI] = 1'b0;
    end
    if (owned_reg[dbgpin_pkg::PIN_TRST]) begin
      pad_out_next[dbgpin_pkg::PIN_TRST] = 1'b0;
      pad_oe_next[dbgpin_pkg::PIN_TRST] = 1'b0;
    end
    if (owned_reg[dbgpin_pkg::PIN_TDO]) begin
      pad_out_next[dbgpin_pkg::PIN_TDO] = tdo_s[0];
      pad_oe_next[dbgpin_pkg::PIN_TDO] = tdo_s[1];
    end else if ((mode_reg == dbgpin_pkg::DBGPIN_SWD_ONLY) && trace_en_reg) begin
      pad_out_next[dbgpin_pkg::PIN_TDO] = trace_bit;
      pad_oe_next[dbgpin_pkg::PIN_TDO] = 1'b1;
    end
  end

  // Pulls applied only on debug owned pins
  function automatic logic [9:0] pulls_of(input logic [4:0] own);
    logic [9:0] p;
    p = {10{1'b0}};
    p[2*dbgpin_pkg::PIN_TMS +: 2] = own[dbgpin_pkg::PIN_TMS] ? dbgpin_pkg::PULL_UP : dbgpin_pkg::PULL_NONE;
    p[2*dbgpin_pkg::PIN_TCK +: 2] = own[dbgpin_pkg::PIN_TCK] ? dbgpin_pkg::PULL_DOWN : dbgpin_pkg::PULL_NONE;
    p[2*dbgpin_pkg::PIN_TDI +: 2] = own[dbgpin_pkg::PIN_TDI] ? dbgpin_pkg::PULL_UP : dbgpin_pkg::PULL_NONE;
    p[2*dbgpin_pkg::PIN_TRST +: 2] = own[dbgpin_pkg::PIN_TRST] ? dbgpin_pkg::PULL_UP : dbgpin_pkg::PULL_NONE;
    pulls_of = p;
  endfunction : pulls_of

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out <= 5'h00;
      pad_oe <= 5'h00;
      pad_pull <= 10'h119;
      debug_owned <= 5'h1f;
      gpio_in <= 5'h00;
    end else begin
      pad_out <= pad_out_next;
      pad_oe <= pad_oe_next;
      pad_pull <= pulls_of(owned_reg);
      debug_owned <= owned_reg;
      gpio_in <= gin_s2 & ~owned_reg;
    end
  end

  assign port_in = port_in_reg;

  // ****************************************
  // Assertions
  // ****************************************
  sequence cfg_write_s;
    psel && penable && pwrite && (paddr == dbgpin_pkg::CFG_OFFSET);
  endsequence

  property mode_follows_p;
    @(posedge pclk) disable iff (!presetn)
      cfg_write_s |-> ##3 (debug_owned == owned_of(dbgpin_pkg::dbgpin_mode_t'($past(pwdata[1:0], 3))));
  endproperty

  mode_release_a: assert property (mode_follows_p) else $error("ownership not updated");
  full_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg == dbgpin_pkg::DBGPIN_FULL) |-> ##1 (owned_reg == 5'h1f)) else $error("full mode");
  no_trst_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg == dbgpin_pkg::DBGPIN_NO_TRST) |-> ##1 (owned_reg == 5'h0f)) else $error("no trst mode");
  swd_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg == dbgpin_pkg::DBGPIN_SWD_ONLY) |-> ##1 (owned_reg == 5'h03)) else $error("swd mode");
  all_released_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg == dbgpin_pkg::DBGPIN_RELEASED) |-> ##2 (debug_owned == 5'h00)) else $error("release mode");
  tck_pull_a: assert property (@(posedge pclk) disable iff (!presetn)
    debug_owned[dbgpin_pkg::PIN_TCK] |-> (pad_pull[3:2] == dbgpin_pkg::PULL_DOWN)) else $error("tck pull");
  tck_input_a: assert property (@(posedge pclk) disable iff (!presetn)
    debug_owned[dbgpin_pkg::PIN_TCK] |-> !pad_oe[dbgpin_pkg::PIN_TCK]) else $error("tck driven");
  trace_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!trace_en_reg && mode_reg == dbgpin_pkg::DBGPIN_SWD_ONLY) [*3]
    |-> (pad_oe[dbgpin_pkg::PIN_TDO] == $past(gpio_oe[dbgpin_pkg::PIN_TDO])))
    else $error("trace driven");
  gpio_back_a: assert property (@(posedge pclk) disable iff (!presetn)
    !owned_reg[dbgpin_pkg::PIN_TDI] |=> (pad_oe[dbgpin_pkg::PIN_TDI] == $past(gpio_oe[dbgpin_pkg::PIN_TDI])))
    else $error("gpio not restored");

  // ****************************************
  // Trace output on test data out pin
  // ****************************************
  sequence trace_on_s;
    (trace_en_reg && mode_reg == dbgpin_pkg::DBGPIN_SWD_ONLY) [*3];
  endsequence

  trace_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    trace_on_s |-> pad_oe[dbgpin_pkg::PIN_TDO])
    else $error("trace not driven");

  trace_data_a: assert property (@(posedge pclk) disable iff (!presetn)
    trace_on_s |-> (pad_out[dbgpin_pkg::PIN_TDO] == $past(trace_bit)))
    else $error("trace data wrong");

  tdo_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    debug_owned[dbgpin_pkg::PIN_TDO] |-> (pad_oe[dbgpin_pkg::PIN_TDO] == $past(tdo_s[1])))
    else $error("test data out enable wrong");

  tdo_data_a: assert property (@(posedge pclk) disable iff (!presetn)
    debug_owned[dbgpin_pkg::PIN_TDO] |-> (pad_out[dbgpin_pkg::PIN_TDO] == $past(tdo_s[0])))
    else $error("test data out value wrong");

  // ****************************************
  // Pulls on owned and released pins
  // ****************************************
  tms_pull_a: assert property (@(posedge pclk) disable iff (!presetn)
    debug_owned[dbgpin_pkg::PIN_TMS] |-> (pad_pull[2*dbgpin_pkg::PIN_TMS +: 2] == dbgpin_pkg::PULL_UP))
    else $error("mode select pull");

  tdi_pull_a: assert property (@(posedge pclk) disable iff (!presetn)
    debug_owned[dbgpin_pkg::PIN_TDI] |-> (pad_pull[2*dbgpin_pkg::PIN_TDI +: 2] == dbgpin_pkg::PULL_UP))
    else $error("data in pull");

  trst_pull_a: assert property (@(posedge pclk) disable iff (!presetn)
    debug_owned[dbgpin_pkg::PIN_TRST] |-> (pad_pull[2*dbgpin_pkg::PIN_TRST +: 2] == dbgpin_pkg::PULL_UP))
    else $error("test reset pull");

  tdo_float_a: assert property (@(posedge pclk) disable iff (!presetn)
    pad_pull[2*dbgpin_pkg::PIN_TDO +: 2] == dbgpin_pkg::PULL_NONE)
    else $error("data out pull");

  tms_free_a: assert property (@(posedge pclk) disable iff (!presetn)
    !debug_owned[dbgpin_pkg::PIN_TMS] |-> (pad_pull[2*dbgpin_pkg::PIN_TMS +: 2] == dbgpin_pkg::PULL_NONE))
    else $error("released mode select pull");

  tck_free_a: assert property (@(posedge pclk) disable iff (!presetn)
    !debug_owned[dbgpin_pkg::PIN_TCK] |-> (pad_pull[2*dbgpin_pkg::PIN_TCK +: 2] == dbgpin_pkg::PULL_NONE))
    else $error("released clock pull");

  trst_free_a: assert property (@(posedge pclk) disable iff (!presetn)
    !debug_owned[dbgpin_pkg::PIN_TRST] |-> (pad_pull[2*dbgpin_pkg::PIN_TRST +: 2] == dbgpin_pkg::PULL_NONE))
    else $error("released test reset pull");

  // ****************************************
  // Pad drive on owned and released pins
  // ****************************************
  tdi_input_a: assert property (@(posedge pclk) disable iff (!presetn)
    debug_owned[dbgpin_pkg::PIN_TDI] |-> !pad_oe[dbgpin_pkg::PIN_TDI])
    else $error("data in driven");

  trst_input_a: assert property (@(posedge pclk) disable iff (!presetn)
    debug_owned[dbgpin_pkg::PIN_TRST] |-> !pad_oe[dbgpin_pkg::PIN_TRST])
    else $error("test reset driven");

  sdo_oe_a: assert property (@(posedge pclk) disable iff (!presetn)
    debug_owned[dbgpin_pkg::PIN_TMS] |-> (pad_oe[dbgpin_pkg::PIN_TMS] == $past(sdo_s[1])))
    else $error("serial data enable wrong");

  sdo_data_a: assert property (@(posedge pclk) disable iff (!presetn)
    debug_owned[dbgpin_pkg::PIN_TMS] |-> (pad_out[dbgpin_pkg::PIN_TMS] == $past(sdo_s[0])))
    else $error("serial data value wrong");

  tms_gpio_a: assert property (@(posedge pclk) disable iff (!presetn)
    !owned_reg[dbgpin_pkg::PIN_TMS] |=> (pad_oe[dbgpin_pkg::PIN_TMS] == $past(gpio_oe[dbgpin_pkg::PIN_TMS])))
    else $error("mode select pin not restored");

  tck_gpio_a: assert property (@(posedge pclk) disable iff (!presetn)
    !owned_reg[dbgpin_pkg::PIN_TCK] |=> (pad_out[dbgpin_pkg::PIN_TCK] == $past(gpio_out[dbgpin_pkg::PIN_TCK])))
    else $error("clock pin not restored");

  trst_gpio_a: assert property (@(posedge pclk) disable iff (!presetn)
    !owned_reg[dbgpin_pkg::PIN_TRST] |=> (pad_oe[dbgpin_pkg::PIN_TRST] == $past(gpio_oe[dbgpin_pkg::PIN_TRST])))
    else $error("test reset pin not restored");

  tdi_gpio_a: assert property (@(posedge pclk) disable iff (!presetn)
    !owned_reg[dbgpin_pkg::PIN_TDI] |=> (pad_out[dbgpin_pkg::PIN_TDI] == $past(gpio_out[dbgpin_pkg::PIN_TDI])))
    else $error("data in pin not restored");

  gpio_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    (gpio_in & debug_owned) == 5'h00)
    else $error("owned pin seen by gpio");

  owned_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> (debug_owned == $past(owned_reg)))
    else $error("ownership output lags");

  // ****************************************
  // Register reads
  // ****************************************
  sequence cfg_read_s;
    psel && !penable && !pwrite && (paddr == dbgpin_pkg::CFG_OFFSET);
  endsequence

  sequence status_read_s;
    psel && !penable && !pwrite && (paddr == dbgpin_pkg::STATUS_OFFSET);
  endsequence

  cfg_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_read_s |=> (pready && prdata == {29'h0, $past(trace_en_reg), $past(mode_reg)}))
    else $error("config read wrong");

  status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_read_s |=> (pready && prdata == {27'h0, $past(owned_reg)}))
    else $error("status read wrong");

  bad_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr != dbgpin_pkg::CFG_OFFSET && paddr != dbgpin_pkg::STATUS_OFFSET)
    |=> (pready && pslverr && prdata == 32'h0000_0000))
    else $error("unmapped access not refused");

  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held");

  // ****************************************
  // Link side sampling
  // ****************************************
  tms_sample_a: assert property (@(posedge tck_link) disable iff (!presetn)
    1'b1 |=> (port_in[0] == $past(pad_in[dbgpin_pkg::PIN_TMS])))
    else $error("mode select not sampled");

  tdi_idle_a: assert property (@(posedge tck_link) disable iff (!presetn)
    !own_tck_s2[0] |=> port_in[1])
    else $error("released data in not high");

  trst_idle_a: assert property (@(posedge tck_link) disable iff (!presetn)
    !own_tck_s2[1] |=> port_in[3])
    else $error("released test reset not high");

  spare_low_a: assert property (@(posedge tck_link) disable iff (!presetn)
    port_in[2] == 1'b0)
    else $error("spare link bit set");

endmodule : dbgpin_top

//--- bench/dbgpin_probe.sv
// Debug probe model driving the five shared pins
// Assumes the device enables decide who owns each pad level
module dbgpin_probe (
  output logic tck_link,
  output logic [4:0] pad_in,
  input wire logic [4:0] pad_out,
  input wire logic [4:0] pad_oe,
  input wire logic go,
  input wire logic [2:0] lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] drv;

  // ****************************************
  // Test clock, runs only within frames
  // ****************************************
  initial tck_link = 1'b0;
  always begin
    #7;
    wait (go);
    tck_link = 1'b1;
    #32;
    tck_link = 1'b0;
    #25;
  end

  // ****************************************
  // Pad levels, never left floating
  // ****************************************
  assign drv = {lvl[2], 1'b1, lvl[1], tck_link, lvl[0]};
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & drv);
endmodule : dbgpin_probe

//--- bench/tb.sv
// Self-checking bench for the debug pin assignment block
// Assumes APB slave at zero wait states and the probe model
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, tck_link, go = 1'b1, trace_bit = 1'b0;
  logic port_sdo = 1'b0, port_sdo_oe = 1'b0, port_tdo = 1'b0, port_tdo_oe = 1'b0;
  logic [4:0] pad_in, pad_out, pad_oe, debug_owned, gpio_in, eoe;
  logic [4:0] gpio_out = 5'h00, gpio_oe = 5'h00;
  logic [9:0] pad_pull;
  logic [3:0] port_in;
  logic [32:0] expq[$];
  int num_errors = 0, checks_done = 0, seed = 32'h7789;
  dbgpin_pkg::dbgpin_mode_t modes[4] = '{dbgpin_pkg::DBGPIN_FULL, dbgpin_pkg::DBGPIN_NO_TRST,
    dbgpin_pkg::DBGPIN_SWD_ONLY, dbgpin_pkg::DBGPIN_RELEASED};
  logic [4:0] owns[4] = '{5'h1f, 5'h0f, 5'h03, 5'h00};

  always #5 pclk = ~pclk;

  dbgpin_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tck_link, .pad_in, .pad_out, .pad_oe, .pad_pull, .debug_owned, .gpio_out, .gpio_oe,
    .gpio_in, .port_sdo, .port_sdo_oe, .port_tdo, .port_tdo_oe, .trace_bit, .port_in);
  dbgpin_probe probe (.tck_link, .pad_in, .pad_out, .pad_oe, .go, .lvl(3'h5));

  // ****************************************
  // Checking helpers
  // ****************************************
  function logic [9:0] epull(input logic [4:0] o);
    epull = {1'b0, o[4], 2'b00, 1'b0, o[2], o[1], 1'b0, 1'b0, o[0]};
  endfunction : epull

  task chk(input logic [32:0] g, input logic [32:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task test_done;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input logic [11:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task pads(input logic [4:0] o);
    repeat (6) @(posedge pclk);
    eoe = (~o & gpio_oe) | (o & {1'b0, port_tdo_oe, 2'b00, port_sdo_oe});
    chk(debug_owned, o);
    chk(pad_pull, epull(o));
    chk(pad_oe, eoe);
    chk(pad_out & ~o, gpio_out & ~o);
    chk(gpio_in, pad_in & ~o);
  endtask : pads

  // ****************************************
  // Read data monitor
  // ****************************************
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk({pslverr, prdata}, expq.size() > 0 ? expq.pop_front() : 33'h0);
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    go <= 1'b0;
    pads(5'h1f);
    rd(dbgpin_pkg::CFG_OFFSET, 33'h0);
    rd(dbgpin_pkg::STATUS_OFFSET, 33'h1f);
    go <= 1'b1;
    repeat (60) @(posedge pclk);
    go <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(port_in, 4'h9);
    rd(12'h008, {1'b1, 32'h0});
    for (int i = 0; i < 4; i++) begin
      gpio_out <= 5'($random(seed));
      gpio_oe <= 5'($random(seed));
      {port_sdo, port_sdo_oe, port_tdo, port_tdo_oe} <= 4'($random(seed));
      apb(1'b1, dbgpin_pkg::CFG_OFFSET, {30'h0, modes[i]});
      pads(owns[i]);
      rd(dbgpin_pkg::STATUS_OFFSET, {28'h0, owns[i]});
    end
    trace_bit <= 1'b1;
    apb(1'b1, dbgpin_pkg::CFG_OFFSET, 32'h7);
    repeat (6) @(posedge pclk);
    chk(pad_oe[3], 1'b1);
    chk(pad_out[3], 1'b1);
    presetn <= 1'b0;
    go <= 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    go <= 1'b0;
    pads(5'h1f);
    test_done();
  end

  initial begin
    #200000;
    num_errors++;
    test_done();
  end
endmodule : tb
